// File: slot_link_params.svh
// Offsets, field positions and reset values for the slot status and
// link control 2 register block. Definitions only.
`ifndef SLOT_LINK_PARAMS_SVH
`define SLOT_LINK_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_SLOT_EVENT_STATUS    8'h80
`define OFS_DEVICE_CAPS_TWO      8'h8C
`define OFS_DEVICE_CONTROL_TWO   8'h90
`define OFS_LINK_CAPS_TWO        8'h94
`define OFS_LINK_CONTROL_TWO     8'h98

// ----------------------------------------
// Slot control fields (low half of 0x80)
// ----------------------------------------
`define SC_ATTN_EN_BIT           0
`define SC_FAULT_EN_BIT          1
`define SC_LATCH_EN_BIT          2
`define SC_PRES_EN_BIT           3
`define SC_CMD_EN_BIT            4
`define SC_HP_IRQ_EN_BIT         5
`define SC_DLL_EN_BIT            12

// ----------------------------------------
// Slot status fields (high half of 0x80)
// ----------------------------------------
`define SS_ATTN_BIT              16
`define SS_FAULT_BIT             17
`define SS_LATCH_CHG_BIT         18
`define SS_PRES_CHG_BIT          19
`define SS_CMD_DONE_BIT          20
`define SS_LATCH_STATE_BIT       21
`define SS_PRES_STATE_BIT        22
`define SS_LOCK_STATE_BIT        23
`define SS_DLL_CHG_BIT           24

// ----------------------------------------
// Capability and control fields
// ----------------------------------------
`define DC2_FWD_BIT              5
`define LC2_SPEED_LSB            0
`define LC2_COMPLIANCE_BIT       4
`define LC2_AUTO_OFF_BIT         5
`define LC2_DEEMPH_BIT           6
`define LC2_MARGIN_LSB           7
`define LC2_MOD_COMP_BIT         10
`define LC2_SKIP_SETS_BIT        11
`define LC2_COMP_DEEMPH_BIT      12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_TARGET_SPEED         4'h2
`define RST_MARGIN               3'h0
`define RST_WORD                 32'h0000_0000

`endif

// File: slot_link_pkg.sv
// Types shared by the slot status and link control 2 register block.
// Assumes nothing of its surroundings.
package slot_link_pkg;

  typedef enum logic [3:0] {
    SPEED_2G5 = 4'b0001,
    SPEED_5G0 = 4'b0010
  } link_speed_e;

  typedef logic [31:0] cfg_word_t;

endpackage

// File: slot_status_link_ctrl2_regs.sv
// Slot status, forwarding capability/control and link control 2 registers
// of one switch port, reached through the port's configuration access.
// Assumes config requests on the core clock; sensor pins are asynchronous.
//
// How it works
// RQ1 - Button press latches status bit 16, W1C
// RQ2 - Power fault latches bit 17, W1C
// RQ3 - Latch sensor change latches bit 18, W1C
// RQ4 - Presence change latches bit 19, W1C
// RQ5 - Command completion latches bit 20, W1C
// RQ6 - Bit 21 shows live latch sensor
// RQ7 - Bit 22 shows live card presence
// RQ8 - No slot implemented: presence reads one
// RQ9 - Bit 23 shows interlock engaged state
// RQ10 - Link-active change latches bit 24, W1C
// RQ11 - Forwarding supported: zero upstream, one downstream
// RQ12 - Forwarding enable RW, reset zero, downstream only
// RQ13 - Target speed codes 1,2; reserved ignored; reset 2
// RQ14 - Writing compliance bit enters compliance, reset zero
// RQ15 - De-emphasis select downstream; reset per port type
// RQ16 - Bits 10-12 RW, reset zero, upstream only
// RQ17 - Interrupt needs event, its enable, master enable
// RQ18 - Zero writes keep; set beats clear
// RQ19 - Unused registers and reserved bits read zero
`timescale 1ns/1ps
`include "slot_link_params.svh"

module slot_status_link_ctrl2_regs
  import slot_link_pkg::*;
#(
  parameter bit IS_DOWNSTREAM   = 1'b1,
  parameter bit SLOT_IMPLEMENTED = 1'b1
) (
  input  wire logic        clock,                 // Core clock, 20 MHz
  input  wire logic        nrst,                  // Port reset, async, low
  input  wire logic [7:0]  cfg_addr,              // Config byte address, dword aligned
  input  wire logic        cfg_wr,                // Config write strobe
  input  wire logic        cfg_rd,                // Config read strobe
  input  wire logic [3:0]  cfg_be,                // Config byte enables
  input  wire logic [31:0] cfg_wdata,             // Config write data
  output logic      [31:0] cfg_rdata,             // Config read data
  output logic             cfg_rvalid,            // Read data valid pulse
  input  wire logic        attn_button_in,        // Attention button pin, high pressed
  input  wire logic        power_fault_in,        // Slot power fault pin, high fault
  input  wire logic        retention_latch_in,    // Latch sensor pin, high open
  input  wire logic        card_present_in,       // Presence pin, high card present
  input  wire logic        mech_latch_lock_in,    // Interlock pin, high engaged
  input  wire logic        cmd_done,              // Hot-plug command finished pulse
  input  wire logic        link_active,           // Link-active level from training
  output logic             hp_irq,                // Hot-plug interrupt level
  output logic             ari_fwd_en,            // Routing-ID forwarding enable
  output logic [3:0]       target_speed,          // Target link speed code
  output logic             enter_compliance,      // Enter compliance request
  output logic             auto_speed_change_off, // Autonomous speed change off
  output logic             deemph_sel,            // 1: -3.5 dB, 0: -6.0 dB
  output logic [2:0]       tx_margin,             // Transmit margin field
  output logic             modified_compliance,   // Modified compliance request
  output logic             compliance_skip_sets,  // Skip sets during compliance
  output logic             compliance_deemph      // Compliance de-emphasis select
);

  localparam int NPIN = 5;
  localparam int P_ATTN  = 0;
  localparam int P_FAULT = 1;
  localparam int P_LATCH = 2;
  localparam int P_PRES  = 3;
  localparam int P_LOCK  = 4;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lane(input logic [31:0] w, input int idx);
    lane = w[idx*8 +: 8];
  endfunction

  // Write-one-to-clear with set priority
  function automatic logic w1c(input logic cur, input logic clr, input logic evt);
    w1c = evt | (cur & ~clr);
  endfunction

  // ----------------------------------------
  // Sensor pin synchronisers
  // ----------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [NPIN-1:0] sync3_r;
  logic [NPIN-1:0] pin_r;
  logic [NPIN-1:0] pin_nxt;
  logic [NPIN-1:0] pin_rise;
  logic [NPIN-1:0] pin_change;

  assign pin_raw = {mech_latch_lock_in, card_present_in, retention_latch_in,
                    power_fault_in, attn_button_in};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Level accepted once the second and third stages agree
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : pin_r[i];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_r <= '0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign pin_rise   = pin_nxt & ~pin_r;
  assign pin_change = pin_nxt ^ pin_r;

  // ----------------------------------------
  // Link-active change detect
  // ----------------------------------------
  logic link_active_prev_r;
  logic link_toggle;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link_active_prev_r <= 1'b0;
    end else begin
      link_active_prev_r <= link_active;
    end
  end

  assign link_toggle = link_active ^ link_active_prev_r;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic wr_slot;
  logic wr_dctl;
  logic wr_lctl;

  assign wr_slot = cfg_wr && (cfg_addr == `OFS_SLOT_EVENT_STATUS) && IS_DOWNSTREAM;
  assign wr_dctl = cfg_wr && (cfg_addr == `OFS_DEVICE_CONTROL_TWO);
  assign wr_lctl = cfg_wr && (cfg_addr == `OFS_LINK_CONTROL_TWO);

  logic [7:0] wb0;
  logic [7:0] wb1;
  logic [7:0] wb2;
  logic [7:0] wb3;

  assign wb0 = lane(cfg_wdata, 0);
  assign wb1 = lane(cfg_wdata, 1);
  assign wb2 = lane(cfg_wdata, 2);
  assign wb3 = lane(cfg_wdata, 3);

  // ----------------------------------------
  // Slot control enables
  // ----------------------------------------
  logic [5:0] slot_en_r;
  logic       dll_en_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slot_en_r <= '0;
      dll_en_r  <= 1'b0;
    end else begin
      if (wr_slot && cfg_be[0]) begin
        slot_en_r <= wb0[5:0];
      end
      if (wr_slot && cfg_be[1]) begin
        dll_en_r <= wb1[`SC_DLL_EN_BIT-8];
      end
    end
  end

  // ----------------------------------------
  // Latched slot events
  // ----------------------------------------
  logic attn_r;
  logic fault_r;
  logic latch_chg_r;
  logic pres_chg_r;
  logic cmd_r;
  logic dll_chg_r;
  logic [7:0] clr2;
  logic       clr_dll;

  assign clr2    = (wr_slot && cfg_be[2]) ? wb2 : 8'h00;
  assign clr_dll = wr_slot && cfg_be[3] && wb3[`SS_DLL_CHG_BIT-24];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      attn_r      <= 1'b0;
      fault_r     <= 1'b0;
      latch_chg_r <= 1'b0;
      pres_chg_r  <= 1'b0;
      cmd_r       <= 1'b0;
      dll_chg_r   <= 1'b0;
    end else if (IS_DOWNSTREAM) begin
      attn_r      <= w1c(attn_r, clr2[`SS_ATTN_BIT-16], pin_rise[P_ATTN]); // RQ1 RQ18
      fault_r     <= w1c(fault_r, clr2[`SS_FAULT_BIT-16], pin_rise[P_FAULT]); // RQ2 RQ18
      latch_chg_r <= w1c(latch_chg_r, clr2[`SS_LATCH_CHG_BIT-16], pin_change[P_LATCH]); // RQ3 RQ18
      pres_chg_r  <= w1c(pres_chg_r, clr2[`SS_PRES_CHG_BIT-16], pin_change[P_PRES]); // RQ4 RQ18
      cmd_r       <= w1c(cmd_r, clr2[`SS_CMD_DONE_BIT-16], cmd_done); // RQ5 RQ18
      dll_chg_r   <= w1c(dll_chg_r, clr_dll, link_toggle); // RQ10 RQ18
    end
  end

  // ----------------------------------------
  // Live slot state
  // ----------------------------------------
  logic latch_state;
  logic pres_state;
  logic lock_state;

  assign latch_state = pin_r[P_LATCH]; // RQ6
  assign pres_state  = SLOT_IMPLEMENTED ? pin_r[P_PRES] : 1'b1; // RQ7 RQ8
  assign lock_state  = pin_r[P_LOCK]; // RQ9

  // ----------------------------------------
  // Hot-plug interrupt
  // ----------------------------------------
  logic irq_nxt;

  always_comb begin
    irq_nxt = slot_en_r[`SC_HP_IRQ_EN_BIT] && IS_DOWNSTREAM &&
              ((attn_r      && slot_en_r[`SC_ATTN_EN_BIT])  ||
               (fault_r     && slot_en_r[`SC_FAULT_EN_BIT]) ||
               (latch_chg_r && slot_en_r[`SC_LATCH_EN_BIT]) ||
               (pres_chg_r  && slot_en_r[`SC_PRES_EN_BIT])  ||
               (cmd_r       && slot_en_r[`SC_CMD_EN_BIT])   ||
               (dll_chg_r   && dll_en_r)); // RQ17
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hp_irq <= 1'b0;
    end else begin
      hp_irq <= irq_nxt;
    end
  end

  // ----------------------------------------
  // Device control 2
  // ----------------------------------------
  logic fwd_en_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fwd_en_r <= 1'b0; // RQ12
    end else if (wr_dctl && cfg_be[0]) begin
      fwd_en_r <= wb0[`DC2_FWD_BIT]; // RQ12
    end
  end

  // ----------------------------------------
  // Link control 2
  // ----------------------------------------
  logic [3:0] speed_r;
  logic       comp_r;
  logic       auto_off_r;
  logic       deemph_r;
  logic [2:0] margin_r;
  logic       mod_comp_r;
  logic       skip_r;
  logic       comp_deemph_r;
  logic       speed_legal;
  logic [15:0] lw;

  assign lw = cfg_wdata[15:0];
  assign speed_legal = (lw[3:0] == SPEED_2G5) || (lw[3:0] == SPEED_5G0);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      speed_r    <= `RST_TARGET_SPEED; // RQ13
      comp_r     <= 1'b0; // RQ14
      auto_off_r <= 1'b0;
      deemph_r   <= IS_DOWNSTREAM; // RQ15
      margin_r   <= `RST_MARGIN;
    end else if (wr_lctl && cfg_be[0]) begin
      if (speed_legal) begin
        speed_r <= lw[3:0]; // RQ13
      end
      comp_r     <= lw[`LC2_COMPLIANCE_BIT]; // RQ14
      auto_off_r <= lw[`LC2_AUTO_OFF_BIT];
      deemph_r   <= lw[`LC2_DEEMPH_BIT]; // RQ15
      margin_r[0] <= lw[`LC2_MARGIN_LSB];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mod_comp_r    <= 1'b0; // RQ16
      skip_r        <= 1'b0;
      comp_deemph_r <= 1'b0;
    end else if (wr_lctl && cfg_be[1]) begin
      mod_comp_r    <= lw[`LC2_MOD_COMP_BIT]; // RQ16
      skip_r        <= lw[`LC2_SKIP_SETS_BIT];
      comp_deemph_r <= lw[`LC2_COMP_DEEMPH_BIT];
    end
  end

  logic [1:0] margin_hi_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      margin_hi_r <= 2'b00;
    end else if (wr_lctl && cfg_be[1]) begin
      margin_hi_r <= lw[9:8];
    end
  end

  // ----------------------------------------
  // Control outputs; forwarding, de-emphasis and compliance bits 10-12 gated by port type
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ari_fwd_en            <= 1'b0;
      target_speed          <= `RST_TARGET_SPEED;
      enter_compliance      <= 1'b0;
      auto_speed_change_off <= 1'b0;
      deemph_sel            <= 1'b0;
      tx_margin             <= `RST_MARGIN;
      modified_compliance   <= 1'b0;
      compliance_skip_sets  <= 1'b0;
      compliance_deemph     <= 1'b0;
    end else begin
      ari_fwd_en            <= fwd_en_r && IS_DOWNSTREAM; // RQ12
      target_speed          <= speed_r;
      enter_compliance      <= comp_r; // RQ14
      auto_speed_change_off <= auto_off_r;
      deemph_sel            <= deemph_r && IS_DOWNSTREAM; // RQ15
      tx_margin             <= {margin_hi_r, margin_r[0]};
      modified_compliance   <= mod_comp_r && !IS_DOWNSTREAM; // RQ16
      compliance_skip_sets  <= skip_r && !IS_DOWNSTREAM; // RQ16
      compliance_deemph     <= comp_deemph_r && !IS_DOWNSTREAM; // RQ16
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  cfg_word_t rd_word;

  always_comb begin
    rd_word = `RST_WORD; // RQ19
    case (cfg_addr)
      `OFS_SLOT_EVENT_STATUS: begin
        if (IS_DOWNSTREAM) begin
          rd_word[5:0]                 = slot_en_r;
          rd_word[`SC_DLL_EN_BIT]      = dll_en_r;
          rd_word[`SS_ATTN_BIT]        = attn_r;
          rd_word[`SS_FAULT_BIT]       = fault_r;
          rd_word[`SS_LATCH_CHG_BIT]   = latch_chg_r;
          rd_word[`SS_PRES_CHG_BIT]    = pres_chg_r;
          rd_word[`SS_CMD_DONE_BIT]    = cmd_r;
          rd_word[`SS_LATCH_STATE_BIT] = latch_state; // RQ6
          rd_word[`SS_PRES_STATE_BIT]  = pres_state; // RQ7 RQ8
          rd_word[`SS_LOCK_STATE_BIT]  = lock_state; // RQ9
          rd_word[`SS_DLL_CHG_BIT]     = dll_chg_r;
        end
      end
      `OFS_DEVICE_CAPS_TWO: begin
        rd_word[`DC2_FWD_BIT] = IS_DOWNSTREAM; // RQ11
      end
      `OFS_DEVICE_CONTROL_TWO: begin
        rd_word[`DC2_FWD_BIT] = fwd_en_r; // RQ19
      end
      `OFS_LINK_CONTROL_TWO: begin
        rd_word[3:0]                   = speed_r;
        rd_word[`LC2_COMPLIANCE_BIT]   = comp_r;
        rd_word[`LC2_AUTO_OFF_BIT]     = auto_off_r;
        rd_word[`LC2_DEEMPH_BIT]       = deemph_r;
        rd_word[9:7]                   = {margin_hi_r, margin_r[0]};
        rd_word[`LC2_MOD_COMP_BIT]     = mod_comp_r;
        rd_word[`LC2_SKIP_SETS_BIT]    = skip_r;
        rd_word[`LC2_COMP_DEEMPH_BIT]  = comp_deemph_r;
      end
      default: begin
        rd_word = `RST_WORD; // RQ19
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata  <= `RST_WORD;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rd_word;
      end
    end
  end

endmodule // slot_status_link_ctrl2_regs

// File: slot_link_checker.sv
// Port checker for the slot status and link control 2 register block.
// Assumes binding onto the block; reads answer one cycle after request.
`timescale 1ns/1ps

module slot_link_checker
  import slot_link_pkg::*;
#(
  parameter bit IS_DOWNSTREAM    = 1'b1,
  parameter bit SLOT_IMPLEMENTED = 1'b1
) (
  input wire logic        clock,               // Core clock
  input wire logic        nrst,                // Async reset, low
  input wire logic [7:0]  cfg_addr,            // Address
  input wire logic        cfg_wr,              // Write strobe
  input wire logic        cfg_rd,              // Read strobe
  input wire logic [3:0]  cfg_be,              // Byte enables
  input wire logic [31:0] cfg_wdata,           // Write data
  input wire logic [31:0] cfg_rdata,           // Read data
  input wire logic        cfg_rvalid,          // Read valid
  input wire logic        cmd_done,            // Command finished
  input wire logic        link_active,         // Link active level
  input wire logic        hp_irq,              // Hot-plug interrupt
  input wire logic        ari_fwd_en,          // Forwarding enable
  input wire logic [3:0]  target_speed,        // Speed code
  input wire logic        enter_compliance,    // Compliance request
  input wire logic        deemph_sel,          // De-emphasis select
  input wire logic        modified_compliance  // Modified compliance
);
  wire rd80 = IS_DOWNSTREAM && cfg_rd && cfg_addr == 8'h80;
  wire wr98 = cfg_wr && cfg_addr == 8'h98;
  wire ok98 = cfg_wdata[3:0] == 4'h1 || cfg_wdata[3:0] == 4'h2;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_cmd_flag;
    $past(cmd_done, 2) && rd80 |=> cfg_rdata[20];
  endproperty
  a_cmd_flag: assert property (p_cmd_flag) else $error("command flag missing");

  property p_dll_flag;
    $past(link_active, 2) != $past(link_active, 3) && rd80 |=> cfg_rdata[24];
  endproperty
  a_dll_flag: assert property (p_dll_flag) else $error("link change flag missing");

  property p_unused_zero;
    cfg_rd && cfg_addr == 8'h94 |=> cfg_rvalid && cfg_rdata == 32'h0000_0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused register not zero");

  property p_fwd_en;
    cfg_wr && cfg_addr == 8'h90 && cfg_be[0] |=> ##1 ari_fwd_en == (IS_DOWNSTREAM && $past(cfg_wdata[5], 2));
  endproperty
  a_fwd_en: assert property (p_fwd_en) else $error("forwarding enable wrong");

  property p_speed_ok;
    wr98 && cfg_be[0] && ok98 |=> ##1 target_speed == $past(cfg_wdata[3:0], 2);
  endproperty
  a_speed_ok: assert property (p_speed_ok) else $error("speed not taken");

  property p_speed_rsv;
    wr98 && cfg_be[0] && !ok98 |=> ##1 $stable(target_speed);
  endproperty
  a_speed_rsv: assert property (p_speed_rsv) else $error("reserved speed taken");

  property p_compliance;
    wr98 && cfg_be[0] |=> ##1 enter_compliance == $past(cfg_wdata[4], 2);
  endproperty
  a_compliance: assert property (p_compliance) else $error("compliance bit wrong");

  property p_deemph;
    wr98 && cfg_be[0] |=> ##1 deemph_sel == (IS_DOWNSTREAM && $past(cfg_wdata[6], 2));
  endproperty
  a_deemph: assert property (p_deemph) else $error("de-emphasis wrong");

  property p_mod_comp;
    wr98 && cfg_be[1] |=> ##1 modified_compliance == (!IS_DOWNSTREAM && $past(cfg_wdata[10], 2));
  endproperty
  a_mod_comp: assert property (p_mod_comp) else $error("modified compliance wrong");

  c_irq: cover property ($rose(hp_irq));
  c_rsv: cover property (wr98 && cfg_be[0] && cfg_wdata[3:0] == 4'h0);
  c_dll: cover property (cfg_rvalid && cfg_rdata[24]);
endmodule // slot_link_checker

bind slot_status_link_ctrl2_regs slot_link_checker #(
  .IS_DOWNSTREAM(IS_DOWNSTREAM), .SLOT_IMPLEMENTED(SLOT_IMPLEMENTED)
) chk_u (.clock, .nrst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata, .cfg_rdata,
  .cfg_rvalid, .cmd_done, .link_active, .hp_irq, .ari_fwd_en, .target_speed,
  .enter_compliance, .deemph_sel, .modified_compliance);

// File: slot_partner_model.sv
// Slot sensors and link training logic facing the register block.
// Assumes the bench calls its tasks; pins move just after a rising edge.
`timescale 1ns/1ps

module slot_partner_model (
  input  wire logic clock,              // Core clock
  output logic      attn_button_in,     // Button
  output logic      power_fault_in,     // Power fault
  output logic      retention_latch_in, // Latch sensor
  output logic      card_present_in,    // Presence
  output logic      mech_latch_lock_in, // Interlock
  output logic      cmd_done,           // Command finished
  output logic      link_active         // Link active
);
  initial begin
    {attn_button_in, power_fault_in, retention_latch_in} = 3'b000;
    {card_present_in, mech_latch_lock_in, cmd_done, link_active} = 4'b0000;
  end

  // Order: button, fault, latch, presence, interlock
  task automatic set_pins(input logic [4:0] lvl);
    @(posedge clock);
    {attn_button_in, power_fault_in, retention_latch_in, card_present_in, mech_latch_lock_in} <= lvl;
  endtask

  task automatic pulse_cmd();
    @(posedge clock);
    cmd_done <= 1'b1;
    @(posedge clock);
    cmd_done <= 1'b0;
  endtask

  task automatic flip_link();
    @(posedge clock);
    link_active <= !link_active;
  endtask
endmodule // slot_partner_model

// File: slot_status_link_ctrl2_regs_bench.sv
// Self-checking bench for the slot status and link control 2 registers.
// Assumes a downstream port with a slot; partner model drives the pins.
`timescale 1ns/1ps

module slot_status_link_ctrl2_regs_bench
  import slot_link_pkg::*;
;
  logic        clock, nrst, cfg_wr, cfg_rd, cfg_rvalid, hp_irq, ari_fwd_en;
  logic        attn_button_in, power_fault_in, retention_latch_in, card_present_in;
  logic        mech_latch_lock_in, cmd_done, link_active, enter_compliance;
  logic        auto_speed_change_off, deemph_sel, modified_compliance;
  logic        compliance_skip_sets, compliance_deemph;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be, target_speed, spd;
  logic [2:0]  tx_margin;
  logic [31:0] cfg_wdata, cfg_rdata;
  int          bad_count, n_compared;

  slot_status_link_ctrl2_regs dut_u (.clock, .nrst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_rvalid, .attn_button_in, .power_fault_in, .retention_latch_in,
    .card_present_in, .mech_latch_lock_in, .cmd_done, .link_active, .hp_irq, .ari_fwd_en,
    .target_speed, .enter_compliance, .auto_speed_change_off, .deemph_sel, .tx_margin,
    .modified_compliance, .compliance_skip_sets, .compliance_deemph);

  slot_partner_model partner_u (.clock, .attn_button_in, .power_fault_in, .retention_latch_in,
    .card_present_in, .mech_latch_lock_in, .cmd_done, .link_active);

  logic [31:0] up_rdata;
  logic        up_deemph, up_mod, up_skip, up_cdeemph;

  // Upstream twin on the same bus and pins, for port-type gating
  slot_status_link_ctrl2_regs #(.IS_DOWNSTREAM(1'b0)) up_u (.clock, .nrst, .cfg_addr, .cfg_wr, .cfg_rd,
    .cfg_be, .cfg_wdata, .cfg_rdata(up_rdata), .cfg_rvalid(), .attn_button_in, .power_fault_in,
    .retention_latch_in, .card_present_in, .mech_latch_lock_in, .cmd_done, .link_active, .hp_irq(),
    .ari_fwd_en(), .target_speed(), .enter_compliance(), .auto_speed_change_off(), .deemph_sel(up_deemph),
    .tx_margin(), .modified_compliance(up_mod), .compliance_skip_sets(up_skip), .compliance_deemph(up_cdeemph));

  initial begin
    clock = 1'b0;
    forever #25 clock = !clock;
  end

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clock);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_be    <= b;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    int i;
    @(posedge clock);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && cfg_rvalid !== 1'b1; i++)
      idle(1);
    if (i == 4) begin
      bad_count++;
      finish_test();
    end else begin
      chk(cfg_rdata, exp);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {nrst, cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
    bad_count  = 0;
    n_compared = 0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    idle(1);
    chk(32'(target_speed), 32'h0000_0002);
    chk(32'(deemph_sel), 32'h0000_0001);
    chk(32'(up_deemph), 32'h0000_0000);
    chk(32'(ari_fwd_en), 32'h0000_0000);
    rd_chk(8'h80, 32'h0000_0000);
    rd_chk(8'h8C, 32'h0000_0020);
    chk(up_rdata, 32'h0000_0000);
    rd_chk(8'h90, 32'h0000_0000);
    rd_chk(8'h94, 32'h0000_0000);
    rd_chk(8'h98, 32'h0000_0042);
    chk(up_rdata, 32'h0000_0002);
    rd_chk(8'h84, 32'h0000_0000);
    spd = SPEED_5G0;
    for (int c = 0; c < 16; c++) begin
      cfg_write(8'h98, 32'(c), 4'b0001);
      if (c == SPEED_2G5 || c == SPEED_5G0)
        spd = c[3:0];
      idle(2);
      chk(32'(target_speed), 32'(spd));
    end
    cfg_write(8'h98, 32'hFFFF_FFF1, 4'b1111);
    idle(2);
    chk(32'({enter_compliance, auto_speed_change_off, deemph_sel, tx_margin, modified_compliance,
      compliance_skip_sets, compliance_deemph, target_speed}), 32'h0000_1F81);
    chk(32'({up_deemph, up_mod, up_skip, up_cdeemph}), 32'h0000_0007);
    rd_chk(8'h98, 32'h0000_1FF1);
    cfg_write(8'h98, 32'h0000_0000, 4'b0010);
    rd_chk(8'h98, 32'h0000_00F1);
    cfg_write(8'h90, 32'hFFFF_FFFF, 4'b1111);
    cfg_write(8'h8C, 32'hFFFF_FFFF, 4'b1111);
    cfg_write(8'h94, 32'hFFFF_FFFF, 4'b1111);
    idle(2);
    chk(32'(ari_fwd_en), 32'h0000_0001);
    rd_chk(8'h90, 32'h0000_0020);
    rd_chk(8'h8C, 32'h0000_0020);
    rd_chk(8'h94, 32'h0000_0000);
    // Slot events with master enable off
    cfg_write(8'h80, 32'h0000_101F, 4'b0011);
    partner_u.set_pins(5'b11111);
    idle(6);
    rd_chk(8'h80, 32'h00EF_101F);
    chk(up_rdata, 32'h0000_0000);
    chk(32'(hp_irq), 32'h0000_0000);
    partner_u.pulse_cmd();
    rd_chk(8'h80, 32'h00FF_101F);
    partner_u.flip_link();
    @(posedge clock);
    rd_chk(8'h80, 32'h01FF_101F);
    cfg_write(8'h80, 32'h0000_103F, 4'b1111);
    idle(2);
    chk(32'(hp_irq), 32'h0000_0001);
    rd_chk(8'h80, 32'h01FF_103F);
    cfg_write(8'h80, 32'h0008_0000, 4'b0100);
    rd_chk(8'h80, 32'h01F7_103F);
    cfg_write(8'h80, 32'h011F_0000, 4'b1100);
    idle(2);
    chk(32'(hp_irq), 32'h0000_0000);
    rd_chk(8'h80, 32'h00E0_103F);
    partner_u.set_pins(5'b00000);
    idle(6);
    rd_chk(8'h80, 32'h000C_103F);
    chk(32'(hp_irq), 32'h0000_0001);
    // Second reset in mid-run
    @(posedge clock);
    nrst <= 1'b0;
    idle(2);
    chk(32'({hp_irq, target_speed}), 32'h0000_0002);
    @(posedge clock);
    nrst <= 1'b1;
    idle(2);
    chk(32'({deemph_sel, ari_fwd_en, hp_irq}), 32'h0000_0004);
    // Link already up at release counts as a change
    rd_chk(8'h80, 32'h0100_0000);
    finish_test();
  end
endmodule // slot_status_link_ctrl2_regs_bench
